//--- rtl/swm_defs.vh
// shared constants of the servo warning manager
`ifndef SWM_DEFS_VH
`define SWM_DEFS_VH
// apb register byte offsets
`define SWM_OFS_LATCH      12'h000
`define SWM_OFS_SEL_ONE    12'h004
`define SWM_OFS_SEL_TWO    12'h008
`define SWM_OFS_MASK_ONE   12'h00c
`define SWM_OFS_MASK_TWO   12'h010
`define SWM_OFS_LINK_ENH   12'h014
`define SWM_OFS_FUNC_ENH3  12'h018
`define SWM_OFS_PL_TIME    12'h01c
`define SWM_OFS_CTRL       12'h020
`define SWM_OFS_ACTIVE     12'h024
`define SWM_OFS_IRQ_STAT   12'h028
`define SWM_OFS_IRQ_MASK   12'h02c
// warning index (position in the internal vector)
`define SWM_NUM_WARN       16
`define SWM_W_OVERLOAD     0
`define SWM_W_REGEN        1
`define SWM_W_BATTERY      2
`define SWM_W_FAN          3
`define SWM_W_ENC_COMM     4
`define SWM_W_ENC_HEAT     5
`define SWM_W_OSC          6
`define SWM_W_LIFETIME     7
`define SWM_W_SCALE_ERR    8
`define SWM_W_SCALE_COMM   9
`define SWM_W_DETERIOR     10
`define SWM_W_LINK_CONT    11
`define SWM_W_LINK_ACC     12
`define SWM_W_LINK_UPD     13
`define SWM_W_POWER_LOSS   14
`define SWM_W_SW_CMD       15
`define SWM_WARN_W         16
// output selection values
`define SWM_SEL_OR_ALL     8'h00
`define SWM_SEL_SW_CMD     8'h1e
// mask bit positions in mask one
`define SWM_M1_BATTERY     0
`define SWM_M1_LIFETIME    2
`define SWM_M1_ENC_HEAT    3
`define SWM_M1_ENC_COMM    4
`define SWM_M1_REGEN       5
`define SWM_M1_FAN         6
`define SWM_M1_OVERLOAD    7
`define SWM_M1_SCALE_ERR   8
`define SWM_M1_LINK_CONT   9
`define SWM_M1_LINK_ACC    10
`define SWM_M1_LINK_UPD    11
`define SWM_M1_POWER_LOSS  12
`define SWM_M1_OSC         13
`define SWM_M1_SCALE_COMM  14
// mask bit positions in mask two
`define SWM_M2_DETERIOR    7
`define SWM_M2_SW_CMD      8
// enhancement bits
`define SWM_LINK_ENH_BIT   0
`define SWM_FENH3_DET_BIT  1
// power loss detection time valid range
`define SWM_PL_MIN         16'd10
`define SWM_PL_MAX         16'd1999
// clock and hold time
`define SWM_CLK_HZ         20000000
`define SWM_HOLD_MS        1000
// control register bit: single-turn absolute function enable
`define SWM_CTRL_SINGLE_TURN 0
`endif

//--- rtl/swm_hold_timer.v
// one-second non-latch hold for one warning
module swm_hold_timer #(
  parameter CNT_W    = 25,
  parameter HOLD_CYC = 20000000
) (
  // clock and reset
  input  wire ref_clk_in,
  input  wire resetn_in,
  // control
  input  wire cause_in,
  input  wire latch_in,
  input  wire clear_in,
  // state
  output reg  held_out
);
  reg [CNT_W-1:0] cnt_q;

  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      held_out <= 1'b0;
      cnt_q    <= {CNT_W{1'b0}};
    end else if (cause_in) begin
      held_out <= 1'b1;
      cnt_q    <= HOLD_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (clear_in) begin
      held_out <= 1'b0;
      cnt_q    <= {CNT_W{1'b0}};
    end else if (held_out && !latch_in) begin
      if (cnt_q == {CNT_W{1'b0}}) begin
        held_out <= 1'b0;
      end else begin
        cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

//--- rtl/swm_power_loss.v
// supply phase dropout timer for main power loss
module swm_power_loss #(
  parameter CNT_W = 16
) (
  // clock and reset
  input  wire             ref_clk_in,
  input  wire             resetn_in,
  // sampled phases, detect time in clock ticks of tick_in
  input  wire             phase_ok_in,
  input  wire             tick_in,
  input  wire [CNT_W-1:0] detect_time_in,
  input  wire             enable_in,
  // result
  output reg              loss_out
);
  reg [CNT_W-1:0] ms_q;

  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      ms_q     <= {CNT_W{1'b0}};
      loss_out <= 1'b0;
    end else if (phase_ok_in || !enable_in) begin
      ms_q     <= {CNT_W{1'b0}};
      loss_out <= 1'b0;
    end else if (tick_in) begin
      if (ms_q >= detect_time_in) begin
        loss_out <= 1'b1;
      end else begin
        ms_q <= ms_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

//--- rtl/swm_top.v
// servo warning manager: detection, mask, latch, output select, apb regs
//
// Contract
// - software command warning on link-enhanced test run
// - main power loss after phase dropout time
// - latch setup picks latch or one-second hold
// - battery and lifetime warnings always latched
// - each output follows its selected warning
// - select zero drives OR of all
// - mask bit one suppresses detection
// - extended warnings disabled by own settings
// - alarm clear clears, live cause re-raises
// - no battery detect in single-turn mode
// - deterioration disabled when enhancement bit clear
// - power loss only for time 10..1999
`include "swm_defs.vh"
module swm_top #(
  parameter HOLD_CYC = (`SWM_CLK_HZ / 1000) * `SWM_HOLD_MS,
  parameter MS_CYC   = `SWM_CLK_HZ / 1000,
  parameter CNT_W    = 25
) (
  // clock and reset
  input  wire        ref_clk_in,
  input  wire        resetn_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  // warning causes from detectors (asynchronous)
  input  wire [13:0] cause_in,
  input  wire        supply_phase_first_ok_in,
  input  wire        supply_phase_third_ok_in,
  input  wire        link_established_in,
  input  wire        sw_op_cmd_in,
  input  wire        alarm_clear_in,
  // warning outputs
  output reg         warn_one_out,
  output reg         warn_two_out,
  output reg         irq_out
);
  // configuration registers
  reg  [15:0] latch_mode_setup_q;
  reg  [7:0]  output_select_one_q;
  reg  [7:0]  output_select_two_q;
  reg  [15:0] warning_mask_one_q;
  reg  [15:0] warning_mask_two_q;
  reg  [15:0] link_enhancement_setting_q;
  reg  [15:0] function_enhancement_three_q;
  reg  [15:0] power_loss_detect_time_q;
  reg  [15:0] ctrl_q;
  reg  [15:0] irq_stat_q;
  reg  [15:0] irq_mask_q;

  // two-flop synchronisers for external inputs, one bank bit per input
  reg  [18:0] sync1_q;
  reg  [18:0] sync2_q;
  reg         clr_d1_q;
  wire [18:0] raw_in = {alarm_clear_in, sw_op_cmd_in, link_established_in,
                        supply_phase_third_ok_in, supply_phase_first_ok_in, cause_in};
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      sync1_q  <= 19'h00000;
      sync2_q  <= 19'h00000;
      clr_d1_q <= 1'b0;
    end else begin
      sync1_q  <= raw_in;
      sync2_q  <= sync1_q;
      clr_d1_q <= sync2_q[18];
    end
  end
  wire [13:0] cause_s   = sync2_q[13:0];
  wire        phase_ok  = sync2_q[14] & sync2_q[15];
  wire        link_s    = sync2_q[16];
  wire        swcmd_s   = sync2_q[17];
  // one clear per request, however long it is held
  wire        clear_p   = sync2_q[18] & ~clr_d1_q;

  // millisecond tick for power loss timing
  // free-running, so a dropout is timed to within one tick
  reg  [CNT_W-1:0] ms_cnt_q;
  wire             ms_tick = (ms_cnt_q == MS_CYC[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1});
  always @(posedge ref_clk_in) begin
    if (!resetn_in || ms_tick) begin
      ms_cnt_q <= {CNT_W{1'b0}};
    end else begin
      ms_cnt_q <= ms_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // power loss in range only
  // an out-of-range time is also the warning's own off switch
  wire pl_enable = (power_loss_detect_time_q >= `SWM_PL_MIN) && (power_loss_detect_time_q <= `SWM_PL_MAX);
  wire pl_loss;
  swm_power_loss #(
    .CNT_W (16)
  ) u_power_loss (
    .ref_clk_in     (ref_clk_in),
    .resetn_in      (resetn_in),
    .phase_ok_in    (phase_ok),
    .tick_in        (ms_tick),
    .detect_time_in (power_loss_detect_time_q),
    .enable_in      (pl_enable),
    .loss_out       (pl_loss)
  );

  // map each warning to its mask bit
  wire [`SWM_WARN_W-1:0] mask_vec;
  assign mask_vec[`SWM_W_OVERLOAD]   = warning_mask_one_q[`SWM_M1_OVERLOAD];
  assign mask_vec[`SWM_W_REGEN]      = warning_mask_one_q[`SWM_M1_REGEN];
  assign mask_vec[`SWM_W_BATTERY]    = warning_mask_one_q[`SWM_M1_BATTERY];
  assign mask_vec[`SWM_W_FAN]        = warning_mask_one_q[`SWM_M1_FAN];
  assign mask_vec[`SWM_W_ENC_COMM]   = warning_mask_one_q[`SWM_M1_ENC_COMM];
  assign mask_vec[`SWM_W_ENC_HEAT]   = warning_mask_one_q[`SWM_M1_ENC_HEAT];
  assign mask_vec[`SWM_W_OSC]        = warning_mask_one_q[`SWM_M1_OSC];
  assign mask_vec[`SWM_W_LIFETIME]   = warning_mask_one_q[`SWM_M1_LIFETIME];
  assign mask_vec[`SWM_W_SCALE_ERR]  = warning_mask_one_q[`SWM_M1_SCALE_ERR];
  assign mask_vec[`SWM_W_SCALE_COMM] = warning_mask_one_q[`SWM_M1_SCALE_COMM];
  assign mask_vec[`SWM_W_DETERIOR]   = warning_mask_two_q[`SWM_M2_DETERIOR];
  assign mask_vec[`SWM_W_LINK_CONT]  = warning_mask_one_q[`SWM_M1_LINK_CONT];
  assign mask_vec[`SWM_W_LINK_ACC]   = warning_mask_one_q[`SWM_M1_LINK_ACC];
  assign mask_vec[`SWM_W_LINK_UPD]   = warning_mask_one_q[`SWM_M1_LINK_UPD];
  assign mask_vec[`SWM_W_POWER_LOSS] = warning_mask_one_q[`SWM_M1_POWER_LOSS];
  assign mask_vec[`SWM_W_SW_CMD]     = warning_mask_two_q[`SWM_M2_SW_CMD];

  // raw causes with per-warning qualifiers; cause bit n feeds warning n
  wire [`SWM_WARN_W-1:0] raw_vec;
  assign raw_vec[`SWM_W_BATTERY-1:0] = cause_s[`SWM_W_BATTERY-1:0];
  assign raw_vec[`SWM_W_BATTERY] = cause_s[`SWM_W_BATTERY] & ~ctrl_q[`SWM_CTRL_SINGLE_TURN];
  assign raw_vec[`SWM_W_DETERIOR-1:`SWM_W_BATTERY+1] = cause_s[`SWM_W_DETERIOR-1:`SWM_W_BATTERY+1];
  assign raw_vec[`SWM_W_DETERIOR]   = cause_s[`SWM_W_DETERIOR] &
                                      function_enhancement_three_q[`SWM_FENH3_DET_BIT];
  assign raw_vec[`SWM_W_LINK_UPD:`SWM_W_LINK_CONT] = cause_s[`SWM_W_LINK_UPD:`SWM_W_LINK_CONT];
  assign raw_vec[`SWM_W_POWER_LOSS] = pl_loss;
  assign raw_vec[`SWM_W_SW_CMD]     = link_enhancement_setting_q[`SWM_LINK_ENH_BIT] & link_s & swcmd_s;

  // a set mask bit stops detection ahead of the hold
  wire [`SWM_WARN_W-1:0] det_vec = raw_vec & ~mask_vec;

  // latch mode per warning; battery and lifetime forced
  wire [`SWM_WARN_W-1:0] latch_vec = latch_mode_setup_q |
                                     (16'h0001 << `SWM_W_BATTERY) | (16'h0001 << `SWM_W_LIFETIME);

  // one hold timer per warning; a live cause outranks the clear
  wire [`SWM_WARN_W-1:0] active_vec;
  genvar gi;
  generate
    for (gi = 0; gi < `SWM_WARN_W; gi = gi + 1) begin : g_hold
      swm_hold_timer #(
        .CNT_W    (CNT_W),
        .HOLD_CYC (HOLD_CYC)
      ) u_hold (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .cause_in   (det_vec[gi]),
        .latch_in   (latch_vec[gi]),
        .clear_in   (clear_p),
        .held_out   (active_vec[gi])
      );
    end
  endgenerate

  // selection value of each warning index
  function [7:0] sel_code;
    input integer idx;
    begin
      case (idx)
        `SWM_W_OVERLOAD:   sel_code = 8'h01;
        `SWM_W_REGEN:      sel_code = 8'h02;
        `SWM_W_BATTERY:    sel_code = 8'h03;
        `SWM_W_FAN:        sel_code = 8'h04;
        `SWM_W_ENC_COMM:   sel_code = 8'h05;
        `SWM_W_ENC_HEAT:   sel_code = 8'h06;
        `SWM_W_OSC:        sel_code = 8'h07;
        `SWM_W_LIFETIME:   sel_code = 8'h08;
        `SWM_W_SCALE_ERR:  sel_code = 8'h09;
        `SWM_W_SCALE_COMM: sel_code = 8'h0a;
        `SWM_W_DETERIOR:   sel_code = 8'h16;
        `SWM_W_LINK_CONT:  sel_code = 8'h0b;
        `SWM_W_LINK_ACC:   sel_code = 8'h0c;
        `SWM_W_LINK_UPD:   sel_code = 8'h0d;
        `SWM_W_POWER_LOSS: sel_code = 8'h0e;
        default:           sel_code = `SWM_SEL_SW_CMD;
      endcase
    end
  endfunction

  // output selection: zero is OR of all, unlisted reads as none
  function pick;
    input [7:0]             sel;
    input [`SWM_WARN_W-1:0] act;
    integer k;
    begin
      pick = 1'b0;
      if (sel == `SWM_SEL_OR_ALL) begin
        pick = |act;
      end else begin
        for (k = 0; k < `SWM_WARN_W; k = k + 1) begin
          if (sel_code(k) == sel) begin
            pick = pick | act[k];
          end
        end
      end
    end
  endfunction

  // interrupt events: rising edge of each active warning
  reg  [`SWM_WARN_W-1:0] active_d_q;
  wire [`SWM_WARN_W-1:0] rise_vec = active_vec & ~active_d_q;

  // apb decode
  wire apb_acc = psel_in & penable_in;
  wire apb_wr  = apb_acc & pwrite_in;
  wire apb_rd  = apb_acc & ~pwrite_in;
  // aligned and inside the register map
  function mapped;
    input [11:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `SWM_OFS_IRQ_MASK);
    end
  endfunction
  // picked in setup, shown in the access cycle
  reg [31:0] rd_mux;
  always @* begin
    case (paddr_in)
      `SWM_OFS_LATCH:     rd_mux = {16'h0000, latch_mode_setup_q};
      `SWM_OFS_SEL_ONE:   rd_mux = {24'h000000, output_select_one_q};
      `SWM_OFS_SEL_TWO:   rd_mux = {24'h000000, output_select_two_q};
      `SWM_OFS_MASK_ONE:  rd_mux = {16'h0000, warning_mask_one_q};
      `SWM_OFS_MASK_TWO:  rd_mux = {16'h0000, warning_mask_two_q};
      `SWM_OFS_LINK_ENH:  rd_mux = {16'h0000, link_enhancement_setting_q};
      `SWM_OFS_FUNC_ENH3: rd_mux = {16'h0000, function_enhancement_three_q};
      `SWM_OFS_PL_TIME:   rd_mux = {16'h0000, power_loss_detect_time_q};
      `SWM_OFS_CTRL:      rd_mux = {16'h0000, ctrl_q};
      `SWM_OFS_ACTIVE:    rd_mux = {16'h0000, active_vec};
      `SWM_OFS_IRQ_STAT:  rd_mux = {16'h0000, irq_stat_q};
      `SWM_OFS_IRQ_MASK:  rd_mux = {16'h0000, irq_mask_q};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      latch_mode_setup_q           <= 16'h0000;
      output_select_one_q          <= 8'h00;
      output_select_two_q          <= 8'h00;
      warning_mask_one_q           <= 16'h0000;
      warning_mask_two_q           <= 16'h0000;
      link_enhancement_setting_q   <= 16'h0000;
      function_enhancement_three_q <= 16'h0000;
      power_loss_detect_time_q     <= 16'h0000;
      ctrl_q                       <= 16'h0000;
      irq_mask_q                   <= 16'h0000;
      irq_stat_q                   <= 16'h0000;
      active_d_q                   <= 16'h0000;
      prdata_out                   <= 32'h00000000;
      pready_out                   <= 1'b0;
      pslverr_out                  <= 1'b0;
      warn_one_out                 <= 1'b0;
      warn_two_out                 <= 1'b0;
      irq_out                      <= 1'b0;
    end else begin
      active_d_q   <= active_vec;
      warn_one_out <= pick(output_select_one_q, active_vec);
      warn_two_out <= pick(output_select_two_q, active_vec);
      irq_out      <= |(irq_stat_q & irq_mask_q);
      // zero wait states: ready follows every setup
      pready_out   <= psel_in & ~penable_in;
      pslverr_out  <= psel_in & ~penable_in & ~mapped(paddr_in);
      prdata_out   <= (psel_in & ~penable_in & ~pwrite_in) ? rd_mux : 32'h00000000;
      // read clears only the bits it returned, so a rise during the access survives
      // prdata_out still holds what this read returned; a new event wins
      if (apb_rd && paddr_in == `SWM_OFS_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~prdata_out[`SWM_WARN_W-1:0]) | rise_vec;
      end else begin
        irq_stat_q <= irq_stat_q | rise_vec;
      end
      if (apb_wr) begin
        case (paddr_in)
          `SWM_OFS_LATCH:     latch_mode_setup_q           <= pwdata_in[15:0];
          `SWM_OFS_SEL_ONE:   output_select_one_q          <= pwdata_in[7:0];
          `SWM_OFS_SEL_TWO:   output_select_two_q          <= pwdata_in[7:0];
          `SWM_OFS_MASK_ONE:  warning_mask_one_q           <= pwdata_in[15:0];
          `SWM_OFS_MASK_TWO:  warning_mask_two_q           <= pwdata_in[15:0];
          `SWM_OFS_LINK_ENH:  link_enhancement_setting_q   <= pwdata_in[15:0];
          `SWM_OFS_FUNC_ENH3: function_enhancement_three_q <= pwdata_in[15:0];
          `SWM_OFS_PL_TIME:   power_loss_detect_time_q     <= pwdata_in[15:0];
          `SWM_OFS_CTRL:      ctrl_q                       <= pwdata_in[15:0];
          `SWM_OFS_IRQ_MASK:  irq_mask_q                   <= pwdata_in[15:0];
          default:            ctrl_q                       <= ctrl_q;
        endcase
      end
    end
  end
endmodule

//--- sim/swm_props.sv
// port assertions for the servo warning manager
module swm_props (
  // clock, reset and apb
  input wire logic        ref_clk_in, resetn_in, psel_in, penable_in, pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in, prdata_out,
  input wire logic        pready_out, pslverr_out,
  // causes and outputs
  input wire logic [13:0] cause_in,
  input wire logic        supply_phase_first_ok_in, supply_phase_third_ok_in,
  input wire logic        link_established_in, sw_op_cmd_in, alarm_clear_in,
  input wire logic        warn_one_out, warn_two_out, irq_out
);
  logic       any_c;
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  // cycles since any cause was seen, saturating
  assign any_c = |cause_in | !supply_phase_first_ok_in | !supply_phase_third_ok_in | sw_op_cmd_in;
  assign quiet_d = any_c ? 4'h0 : (quiet_q == 4'hf ? quiet_q : quiet_q + 4'h1);
  always @(posedge ref_clk_in) begin
    quiet_q <= resetn_in ? quiet_d : 4'h0;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  property p_rdy; psel_in && !penable_in |=> pready_out; endproperty
  property p_one; pready_out |=> !pready_out; endproperty
  property p_err; pslverr_out |-> pready_out; endproperty
  property p_rdat; !pready_out |-> prdata_out == 32'h0; endproperty
  property p_rst;
    disable iff (1'b0) !resetn_in |=> !warn_one_out && !warn_two_out && !irq_out;
  endproperty
  property p_rise1; $rose(warn_one_out) |-> quiet_q < 4'h8; endproperty
  property p_rise2; $rose(warn_two_out) |-> quiet_q < 4'h8; endproperty
  property p_clr;
    $rose(alarm_clear_in) && quiet_q >= 4'h8 ##1 !any_c [*7] |=> !warn_one_out && !warn_two_out;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error without ready");
  a_rdat: assert property (p_rdat) else $error("read data outside access");
  a_rst: assert property (p_rst) else $error("outputs high in reset");
  a_rise1: assert property (p_rise1) else $error("output one rose without cause");
  a_rise2: assert property (p_rise2) else $error("output two rose without cause");
  a_clr: assert property (p_clr) else $error("warning kept after clear");
  c_warn: cover property ($rose(warn_one_out));
  c_clr: cover property ($rose(alarm_clear_in) && quiet_q >= 4'h8);
  c_err: cover property (pslverr_out);
  c_irq: cover property (irq_out);
endmodule

bind swm_top swm_props u_props (.ref_clk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
  .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .cause_in, .supply_phase_first_ok_in,
  .supply_phase_third_ok_in, .link_established_in, .sw_op_cmd_in, .alarm_clear_in, .warn_one_out,
  .warn_two_out, .irq_out);

//--- sim/swm_host_model.sv
// host controller side: link bring-up and setup software commands
module swm_host_model #(
  parameter int LINK_LAT = 4
) (
  input  wire logic ref_clk_in,
  input  wire logic link_req_in,
  input  wire logic op_req_in,
  output logic      link_established_out,
  output logic      sw_op_cmd_out
);
  int cnt_q = 0;
  initial begin
    link_established_out = 1'b0;
    sw_op_cmd_out = 1'b0;
  end
  // link comes up LINK_LAT+1 cycles after the request
  always @(posedge ref_clk_in) begin
    cnt_q <= link_req_in ? (cnt_q < LINK_LAT ? cnt_q + 1 : cnt_q) : 0;
    link_established_out <= link_req_in && cnt_q >= LINK_LAT;
    sw_op_cmd_out <= op_req_in && link_established_out;
  end
endmodule

//--- sim/tb.sv
// self-checking bench for the servo warning manager
`include "swm_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [13:0] cause_in = 14'h0;
  logic        ph1 = 1'b1;
  logic        ph3 = 1'b1;
  logic        link_req = 1'b0;
  logic        op_req = 1'b0;
  logic        clr = 1'b0;
  logic [31:0] prdata_out;
  logic [31:0] rd;
  logic        pready_out, pslverr_out, link_up, sw_op, w1, w2, irq, er;
  int          fails = 0;
  int          n_compared = 0;
  int          sel_t[14] = '{1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 22, 11, 12, 13};
  int          msk_t[14] = '{7, 5, 0, 6, 4, 3, 13, 2, 8, 14, 0, 9, 10, 11};

  always #25 ref_clk_in = ~ref_clk_in;

  swm_top #(.HOLD_CYC(50), .MS_CYC(5)) DUT (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .cause_in(cause_in), .supply_phase_first_ok_in(ph1), .supply_phase_third_ok_in(ph3),
    .link_established_in(link_up), .sw_op_cmd_in(sw_op), .alarm_clear_in(clr),
    .warn_one_out(w1), .warn_two_out(w2), .irq_out(irq));
  swm_host_model #(.LINK_LAT(6)) u_host (.ref_clk_in(ref_clk_in), .link_req_in(link_req),
    .op_req_in(op_req), .link_established_out(link_up), .sw_op_cmd_out(sw_op));

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 20);
    if (k >= 20) fails++;
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic pulse(input int i, input int n);
    cause_in[i] <= 1'b1;
    cyc(n);
    cause_in[i] <= 1'b0;
  endtask
  // quiet gap, then an alarm clear pulse
  task automatic aclr();
    cyc(10);
    clr <= 1'b1;
    cyc(3);
    clr <= 1'b0;
    cyc(12);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    fails++;
    print_verdict();
  end

  initial begin
    cyc(3);
    resetn_in <= 1'b1;
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, `SWM_OFS_SEL_TWO, 32'h4);
    apb(1'b0, `SWM_OFS_SEL_TWO, 32'h0);
    chk("sel two", rd, 32'h4);
    $display("registers done");
    apb(1'b1, `SWM_OFS_LATCH, 32'h0);
    apb(1'b1, `SWM_OFS_IRQ_MASK, 32'h0);
    apb(1'b0, `SWM_OFS_IRQ_STAT, 32'h0);
    for (int i = 0; i < 14; i++) begin
      if (i == 10) continue;
      apb(1'b1, `SWM_OFS_SEL_ONE, 32'(sel_t[i]));
      apb(1'b1, `SWM_OFS_MASK_ONE, 32'h1 << msk_t[i]);
      pulse(i, 5);
      cyc(8);
      chk("masked", {31'h0, w1}, 32'h0);
      apb(1'b1, `SWM_OFS_MASK_ONE, 32'h0);
      pulse(i, 5);
      cyc(3);
      chk("selected", {31'h0, w1}, 32'h1);
      chk("other", {31'h0, w2}, 32'(i == 3));
      aclr();
      chk("cleared", {31'h0, w1}, 32'h0);
    end
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, `SWM_OFS_IRQ_MASK, 32'hffff);
    cyc(3);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b0, `SWM_OFS_IRQ_STAT, 32'h0);
    chk("irq stat", rd, 32'h3bff);
    cyc(3);
    chk("irq off", {31'h0, irq}, 32'h0);
    $display("codes done");
    apb(1'b1, `SWM_OFS_SEL_ONE, 32'h1);
    pulse(0, 5);
    cyc(30);
    chk("held", {31'h0, w1}, 32'h1);
    cyc(45);
    chk("hold over", {31'h0, w1}, 32'h0);
    apb(1'b1, `SWM_OFS_LATCH, 32'h1);
    pulse(0, 5);
    cyc(100);
    chk("latched", {31'h0, w1}, 32'h1);
    apb(1'b0, `SWM_OFS_ACTIVE, 32'h0);
    chk("active", rd, 32'h1);
    cause_in[0] <= 1'b1;
    aclr();
    chk("re-raised", {31'h0, w1}, 32'h1);
    cause_in[0] <= 1'b0;
    aclr();
    chk("clr", {31'h0, w1}, 32'h0);
    apb(1'b1, `SWM_OFS_LATCH, 32'h0);
    $display("latch done");
    apb(1'b1, `SWM_OFS_SEL_ONE, 32'h0);
    apb(1'b1, `SWM_OFS_SEL_TWO, 32'h3);
    pulse(2, 5);
    cyc(100);
    chk("battery", {31'h0, w2}, 32'h1);
    chk("or all", {31'h0, w1}, 32'h1);
    aclr();
    apb(1'b1, `SWM_OFS_CTRL, 32'h1);
    pulse(2, 5);
    cyc(8);
    chk("single turn", {31'h0, w2}, 32'h0);
    apb(1'b1, `SWM_OFS_CTRL, 32'h0);
    apb(1'b1, `SWM_OFS_SEL_ONE, 32'h16);
    apb(1'b1, `SWM_OFS_FUNC_ENH3, 32'h0);
    pulse(10, 5);
    cyc(3);
    chk("diag off", {31'h0, w1}, 32'h0);
    apb(1'b1, `SWM_OFS_FUNC_ENH3, 32'h2);
    pulse(10, 5);
    cyc(3);
    chk("diag on", {31'h0, w1}, 32'h1);
    aclr();
    $display("battery diag done");
    apb(1'b1, `SWM_OFS_SEL_ONE, 32'h1e);
    link_req <= 1'b1;
    op_req <= 1'b1;
    cyc(20);
    chk("no enh", {31'h0, w1}, 32'h0);
    apb(1'b1, `SWM_OFS_MASK_TWO, 32'h100);
    apb(1'b1, `SWM_OFS_LINK_ENH, 32'h1);
    cyc(8);
    chk("mask two", {31'h0, w1}, 32'h0);
    apb(1'b1, `SWM_OFS_MASK_TWO, 32'h0);
    cyc(8);
    chk("sw cmd", {31'h0, w1}, 32'h1);
    op_req <= 1'b0;
    aclr();
    $display("command done");
    apb(1'b1, `SWM_OFS_SEL_ONE, 32'he);
    ph1 <= 1'b0;
    cyc(80);
    chk("detect off", {31'h0, w1}, 32'h0);
    ph1 <= 1'b1;
    apb(1'b1, `SWM_OFS_PL_TIME, 32'ha);
    ph1 <= 1'b0;
    cyc(40);
    ph1 <= 1'b1;
    cyc(8);
    chk("short dip", {31'h0, w1}, 32'h0);
    ph3 <= 1'b0;
    cyc(80);
    chk("power loss", {31'h0, w1}, 32'h1);
    ph3 <= 1'b1;
    aclr();
    apb(1'b1, `SWM_OFS_PL_TIME, 32'h5);
    ph1 <= 1'b0;
    cyc(80);
    chk("out of range", {31'h0, w1}, 32'h0);
    ph1 <= 1'b1;
    $display("power done");
    print_verdict();
  end
endmodule
